/* File: logic/spd_cfg.svh */
// Constants for the serial programming and debug slave
`ifndef SPD_CFG_SVH
`define SPD_CFG_SVH
`define SPD_CMD_BITS 8
`define SPD_ADDR_BITS 16
`define SPD_WORD_BITS 16
`define SPD_FIFO_DEPTH 8
`define SPD_CMD_READ 8'h03
`define SPD_CMD_WRITE 8'h02
`define SPD_CMD_LAST 4'h7
`define SPD_WORD_LAST 4'hF
`define SPD_CNT_ZERO 4'h0
`define SPD_CNT_STEP 4'h1
`define SPD_ADDR_STEP 16'h0001
`define SPD_SYNC_CLK 0
`define SPD_SYNC_CS 1
`define SPD_SYNC_MOSI 2
`define SPD_SYNC_W 3
`define SPD_SYNC_RST 3'h2
`endif

/* File: logic/spd_pkg.sv */
// Types of the serial programming and debug slave
`default_nettype none
package spd_pkg;
  typedef enum logic [2:0] {
    SPD_IDLE,
    SPD_CMD,
    SPD_ADDR,
    SPD_WDATA,
    SPD_RDATA,
    SPD_IGNORE
  } spd_state_e;
endpackage
`default_nettype wire

/* File: logic/spd_fifo.sv */
// Word FIFO with registered show-ahead output
`default_nettype none
module spd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] SHOW_FULL = CW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshake terms
  // Room counts the show-ahead register too, so DEPTH words in total
  assign in_ready_o = out_valid_o ? (count < SHOW_FULL) : (count != FULL);
  assign push = in_valid_i && in_ready_o;
  assign pop = (count != '0) && (!out_valid_o || out_ready_i);

  // Storage array
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == LAST) ? '0 : rptr + AW'(1);
      end
      if (push && !pop) begin
        count <= count + CW'(1);
      end else if (pop && !push) begin
        count <= count - CW'(1);
      end
    end
  end

  // Output register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (pop) begin
      out_valid_o <= 1'b1;
      out_data_o <= mem[rptr];
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: logic/spd_slave.sv */
// Serial programming and debug slave port
`include "spd_cfg.svh"
`default_nettype none
// Contract
// - Select low, then eight command bits
// - Sixteen address bits give first location
// - Sixteen-bit data words in or out
// - Select low throughout; high ends transaction
// - Input sampled on serial clock rise
// - Output changes on serial clock fall
// - Each further sixteen clocks, address increments
// - Deselected output driven: halted high, running low
// - Works with processor running or halted
module spd_slave #(
  parameter logic [`SPD_CMD_BITS-1:0] CMD_READ = `SPD_CMD_READ,
  parameter logic [`SPD_CMD_BITS-1:0] CMD_WRITE = `SPD_CMD_WRITE,
  parameter int FIFO_DEPTH = `SPD_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic cpu_halted_i,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [`SPD_ADDR_BITS-1:0] wr_addr_o,
  output logic [`SPD_WORD_BITS-1:0] wr_data_o,
  output logic rd_req_o,
  output logic [`SPD_ADDR_BITS-1:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [`SPD_WORD_BITS-1:0] rd_data_i,
  output logic wr_overrun_o,
  output logic busy_o
);
  localparam int FW = `SPD_ADDR_BITS + `SPD_WORD_BITS;
  localparam logic [`SPD_SYNC_W-1:0] SYNC_RST = `SPD_SYNC_RST;

  logic [`SPD_SYNC_W-1:0] sync1;
  logic [`SPD_SYNC_W-1:0] sync2;
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic mosi;
  spd_pkg::spd_state_e state;
  logic [3:0] bitcnt;
  logic [`SPD_WORD_BITS-1:0] shift_in;
  logic [`SPD_WORD_BITS-1:0] next_word;
  logic [`SPD_WORD_BITS-1:0] shift_out;
  logic [`SPD_WORD_BITS-1:0] rd_buf;
  logic [`SPD_ADDR_BITS-1:0] addr;
  logic field_done;
  logic push;
  logic push_ready;
  logic [FW-1:0] push_data;
  logic [FW-1:0] fifo_dout;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for the serial pins
  generate
    for (genvar i = 0; i < `SPD_SYNC_W; i++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          sync1[i] <= SYNC_RST[i];
          sync2[i] <= SYNC_RST[i];
        end else begin
          sync1[i] <= (i == `SPD_SYNC_CLK) ? spi_clk_i :
                      (i == `SPD_SYNC_CS) ? spi_cs_n_i : spi_mosi_i;
          sync2[i] <= sync1[i];
        end
      end
    end
  endgenerate

  // Serial clock edge finder, looking only at the second stage
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sync2[`SPD_SYNC_CLK];
    end
  end

  // The master owns the clock; the port only watches it
  assign sclk_rise = sync2[`SPD_SYNC_CLK] && !sclk_prev;
  assign sclk_fall = !sync2[`SPD_SYNC_CLK] && sclk_prev;
  assign cs_high = sync2[`SPD_SYNC_CS];
  assign mosi = sync2[`SPD_SYNC_MOSI];
  assign next_word = {shift_in[`SPD_WORD_BITS-2:0], mosi};
  assign field_done = (state == spd_pkg::SPD_CMD) ? (bitcnt == `SPD_CMD_LAST) :
                      (bitcnt == `SPD_WORD_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Transaction sequencer; a high select holds it in reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= spd_pkg::SPD_IDLE;
    end else if (cs_high) begin
      state <= spd_pkg::SPD_IDLE;
    end else begin
      unique case (state)
        spd_pkg::SPD_IDLE: begin
          state <= spd_pkg::SPD_CMD;
        end
        spd_pkg::SPD_CMD: begin
          if (sclk_rise && field_done) begin
            if (next_word[`SPD_CMD_BITS-1:0] == CMD_READ) begin
              state <= spd_pkg::SPD_ADDR;
            end else if (next_word[`SPD_CMD_BITS-1:0] == CMD_WRITE) begin
              state <= spd_pkg::SPD_ADDR;
            end else begin
              state <= spd_pkg::SPD_IGNORE;
            end
          end
        end
        spd_pkg::SPD_ADDR: begin
          if (sclk_rise && field_done) begin
            state <= (shift_out[0]) ? spd_pkg::SPD_RDATA : spd_pkg::SPD_WDATA;
          end
        end
        spd_pkg::SPD_WDATA: begin
          state <= spd_pkg::SPD_WDATA;
        end
        spd_pkg::SPD_RDATA: begin
          state <= spd_pkg::SPD_RDATA;
        end
        spd_pkg::SPD_IGNORE: begin
          state <= spd_pkg::SPD_IGNORE;
        end
      endcase
    end
  end

  // Input shifter and bit counter, sampled on the rising edge
  always_ff @(posedge clk_i) begin
    if (!rstn_i || cs_high) begin
      shift_in <= '0;
      bitcnt <= `SPD_CNT_ZERO;
    end else if (sclk_rise && state != spd_pkg::SPD_IDLE) begin
      shift_in <= next_word;
      bitcnt <= field_done ? `SPD_CNT_ZERO : bitcnt + `SPD_CNT_STEP;
    end
  end

  // Address register: loaded after the address field, then stepped per word
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      addr <= '0;
    end else if (sclk_rise && field_done && state == spd_pkg::SPD_ADDR) begin
      addr <= next_word;
    end else if (push) begin
      addr <= addr + `SPD_ADDR_STEP;
    end else if (sclk_fall && state == spd_pkg::SPD_RDATA && bitcnt == `SPD_CNT_ZERO) begin
      addr <= addr + `SPD_ADDR_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path: each completed word that finds room goes into the FIFO with its address
  assign push = sclk_rise && field_done && state == spd_pkg::SPD_WDATA && !cs_high;
  assign push_data = {addr, next_word};

  spd_fifo #(
    .W(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push),
    .in_ready_o(push_ready),
    .in_data_i(push_data),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_dout)
  );

  assign wr_addr_o = fifo_dout[FW-1:`SPD_WORD_BITS];
  assign wr_data_o = fifo_dout[`SPD_WORD_BITS-1:0];

  // A word that finds the FIFO full is dropped and flagged
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_overrun_o <= 1'b0;
    end else if (push && !push_ready) begin
      wr_overrun_o <= 1'b1;
    end else if (state == spd_pkg::SPD_IDLE && !cs_high) begin
      wr_overrun_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read requests: one after the address, one ahead of each next word
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_req_o <= 1'b0;
      rd_addr_o <= '0;
    end else if (!cs_high && sclk_rise && field_done && state == spd_pkg::SPD_ADDR &&
                 shift_out[0]) begin
      rd_req_o <= 1'b1;
      rd_addr_o <= next_word;
    end else if (!cs_high && sclk_fall && state == spd_pkg::SPD_RDATA &&
                 bitcnt == `SPD_CNT_ZERO) begin
      rd_req_o <= 1'b1;
      rd_addr_o <= addr + `SPD_ADDR_STEP;
    end else begin
      rd_req_o <= 1'b0;
    end
  end

  // Prefetched read word; independent of processor run state
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_buf <= '0;
    end else if (rd_valid_i) begin
      rd_buf <= rd_data_i;
    end
  end

  // Output shifter; bit 0 also remembers a read command during the address
  always_ff @(posedge clk_i) begin
    if (!rstn_i || cs_high) begin
      shift_out <= '0;
    end else if (state == spd_pkg::SPD_CMD && sclk_rise && field_done) begin
      shift_out <= {{(`SPD_WORD_BITS-1){1'b0}}, next_word[`SPD_CMD_BITS-1:0] == CMD_READ};
    end else if (state == spd_pkg::SPD_RDATA && sclk_fall) begin
      if (bitcnt == `SPD_CNT_ZERO) begin
        shift_out <= {rd_buf[`SPD_WORD_BITS-2:0], 1'b0};
      end else begin
        shift_out <= {shift_out[`SPD_WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // Serial output: run state while deselected, data on falling edges
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      spi_miso_o <= 1'b0;
    end else if (cs_high) begin
      spi_miso_o <= cpu_halted_i;
    end else if (state == spd_pkg::SPD_RDATA && sclk_fall) begin
      spi_miso_o <= (bitcnt == `SPD_CNT_ZERO) ? rd_buf[`SPD_WORD_BITS-1] :
                    shift_out[`SPD_WORD_BITS-1];
    end else if (state != spd_pkg::SPD_RDATA) begin
      spi_miso_o <= 1'b0;
    end
  end

  // Busy while a transaction is open
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= !cs_high;
    end
  end
endmodule
`default_nettype wire

/* File: sim/spd_slave_asserts.sv */
// Property checker for the serial debug slave
`default_nettype none
module spd_slave_asserts (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic cpu_halted_i,
  input wire logic wr_valid_o,
  input wire logic wr_ready_i,
  input wire logic [15:0] wr_addr_o,
  input wire logic [15:0] wr_data_o,
  input wire logic rd_req_o,
  input wire logic wr_overrun_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // One clock and reset for every property
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  idle_level_a: assert property (
    (spi_cs_n_i && $stable(cpu_halted_i))[*6] |-> spi_miso_o == cpu_halted_i)
    else $error("idle output level wrong");
  busy_open_a: assert property ((!spi_cs_n_i)[*4] |-> busy_o)
    else $error("busy missing while selected");
  busy_end_a: assert property (spi_cs_n_i[*4] |-> !busy_o)
    else $error("busy while deselected");
  rd_pulse_a: assert property (rd_req_o |=> !rd_req_o)
    else $error("read request longer than one cycle");
  wr_hold_a: assert property (
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_addr_o) && $stable(wr_data_o))
    else $error("write word not held");
  miso_fall_a: assert property (
    !spi_cs_n_i && $changed(spi_miso_o) |-> !$past(spi_clk_i, 2))
    else $error("output changed near rising edge");
  rd_in_txn_a: assert property (rd_req_o |-> busy_o)
    else $error("read request outside transaction");
  ovr_clear_a: assert property ($rose(busy_o) |-> ##[0:2] !wr_overrun_o)
    else $error("overrun not cleared");
endmodule
////////////////////////////////////////////////////////////
bind spd_slave spd_slave_asserts u_chk (.clk_i, .rstn_i, .spi_clk_i, .spi_cs_n_i,
  .spi_miso_o, .cpu_halted_i, .wr_valid_o, .wr_ready_i, .wr_addr_o, .wr_data_o,
  .rd_req_o, .wr_overrun_o, .busy_o);
`default_nettype wire

/* File: sim/spd_master.sv */
// Serial master model driving the debug slave
`default_nettype none
module spd_master (
  output logic spi_clk_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o,
  input wire logic spi_miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle: clock low, deselected
  initial begin
    spi_clk_o = 1'h0;
    spi_cs_n_o = 1'h1;
    spi_mosi_o = 1'h0;
  end
  // Shifts n bits MSB first, 64 ns period, captures on the rise
  task automatic shift(input logic [23:0] v, input int n, output logic [23:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi_o = v[i];
      #32 spi_clk_o = 1'h1;
      r = {r[22:0], spi_miso_i};
      #32 spi_clk_o = 1'h0;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // One transaction; one captured word per word sent
  task automatic frame(input logic [7:0] cmd, input logic [15:0] a,
      input logic [15:0] w [$], output logic [15:0] rd [$]);
    logic [23:0] r;
    rd = {};
    #128 spi_cs_n_o = 1'h0;
    #32;
    shift({cmd, a}, 24, r);
    foreach (w[i]) begin
      shift({8'h00, w[i]}, 16, r);
      rd.push_back(r[15:0]);
    end
    #32 spi_cs_n_o = 1'h1;
    spi_mosi_o = ~spi_mosi_o;
  endtask
endmodule
`default_nettype wire

/* File: sim/spd_slave_test.sv */
// Self-checking bench for the serial debug slave
`include "spd_cfg.svh"
`default_nettype none
module spd_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] cmd; logic [15:0] addr; logic halt;} spd_row_s;
  spd_row_s rows [4] = '{'{`SPD_CMD_WRITE, 16'h1234, 1'h0}, '{`SPD_CMD_WRITE, 16'hFFFF, 1'h1},
    '{`SPD_CMD_READ, 16'h0100, 1'h0}, '{`SPD_CMD_READ, 16'hFFFE, 1'h1}};
  logic clk_i = 1'h0, rstn_i = 1'h0, halted = 1'h0, wr_ready = 1'h1, rd_valid = 1'h0;
  logic sclk, cs_n, mosi, miso, wr_valid, rd_req, ovr, busy;
  logic [15:0] wr_addr, wr_data, rd_addr, a, b, rd_data = 16'h0000;
  logic [31:0] wq [$];
  logic [15:0] wd [$], rd [$];
  int n_errors = 0, n_checks = 0, cyc = 0, n_req = 0;
  spd_slave u_dut (.clk_i, .rstn_i, .spi_clk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .cpu_halted_i(halted), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
    .rd_valid_i(rd_valid), .rd_data_i(rd_data), .wr_overrun_o(ovr), .busy_o(busy));
  spd_master u_mst (.spi_clk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_miso_i(miso));
  // Clock
  initial forever #2.5 clk_i = ~clk_i;
  // Memory answer, write capture, cycle ceiling
  always @(posedge clk_i) begin
    if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    if (rd_req) n_req++;
    rd_valid <= #1 rd_req;
    rd_data <= #1 rd_addr ^ 16'h9696;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Row loop, then overrun, ignored command and reset cases
  initial begin
    step(20);
    rstn_i = 1'h1;
    foreach (rows[k]) begin
      halted = rows[k].halt;
      a = rows[k].addr;
      step(8);
      chk(miso, halted);
      wd = {a ^ 16'h3C5A, 16'(a + 16'h0001) ^ 16'h3C5A};
      wq = {};
      u_mst.frame(rows[k].cmd, a, wd, rd);
      step(8);
      chk(wq.size(), rows[k].cmd == `SPD_CMD_WRITE ? 2 : 0);
      for (int i = 0; i < 2; i++) begin
        b = a + 16'(i);
        if (rows[k].cmd == `SPD_CMD_WRITE) chk(wq[i], {b, b ^ 16'h3C5A});
        else chk(rd[i], b ^ 16'h9696);
      end
      $display("row %0d done", k);
    end
    halted = 1'h0;
    wr_ready = 1'h0;
    wd = {};
    for (int i = 0; i < 9; i++) wd.push_back(16'hA000 + 16'(i));
    wq = {};
    u_mst.frame(`SPD_CMD_WRITE, 16'h0040, wd, rd);
    step(8);
    chk(ovr, 1);
    wr_ready = 1'h1;
    step(20);
    chk(wq.size(), 8);
    chk(wq[7], {16'h0047, 16'hA007});
    $display("overrun done");
    n_req = 0;
    wq = {};
    u_mst.frame(8'hFF, 16'h0040, wd, rd);
    step(8);
    chk({ovr, 15'(n_req), 16'(wq.size())}, 0);
    $display("ignored command done");
    rstn_i = 1'h0;
    step(3);
    chk({miso, wr_valid, rd_req, ovr, busy}, 0);
    halted = 1'h1;
    rstn_i = 1'h1;
    step(6);
    chk(miso, 1);
    $display("reset done");
    test_done();
  end
endmodule
`default_nettype wire
